/* design/rps_regs.svh */
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// Byte offsets of the per-block register triple
`define RPS_POWER_OFS    12'h900
`define RPS_SET_OFS      12'h904
`define RPS_CLR_OFS      12'h908
`define RPS_STRIDE       12'h010

// Block and section counts
`define RPS_NUM_BLOCKS   8
`define RPS_NUM_SECT     2

// Blocks whose memory slave exists; an absent block reads zero and ignores writes
`define RPS_PRESENT      8'hFF

// Reset value and writable fields of the combined power state register
`define RPS_POWER_RESET  32'h0000FFFF
`define RPS_WMASK        32'h00030003

// Field positions: section on-bits and section keep-bits
`define RPS_ON_LSB       0
`define RPS_KEEP_LSB     16

// Bus answer: cycles from request to waitrequest low
`define RPS_ACK_CYCLES   1

`endif

/* design/rps_pkg.sv */
package rps_pkg;

   // Bus slave states
   typedef enum logic [0:0] {
      RPS_BUS_IDLE,
      RPS_BUS_ACK
   } rps_bus_e;

   // Kind of register an address hits
   typedef enum logic [1:0] {
      RPS_ACC_NONE,
      RPS_ACC_POWER,
      RPS_ACC_SET,
      RPS_ACC_CLR
   } rps_acc_e;

   // State of one block's power register
   typedef struct packed {
      logic [31:0] power;
   } rps_cell_s;

   // State of the top level
   typedef struct packed {
      rps_bus_e    st;
      logic [31:0] rdata;
      logic [15:0] on;
      logic [15:0] keep;
   } rps_main_s;

endpackage

/* design/rps_power_cell.sv */
`timescale 1ns/100ps
`include "rps_regs.svh"

// Combined power state register of one memory block, with set and clear access
module rps_power_cell (
   input  wire logic        core_clk_i,  // System clock
   input  wire logic        arst_n_i,    // Async reset, active low
   input  wire logic        wr_i,        // Direct write strobe
   input  wire logic        set_i,       // Write-ones-to-set strobe
   input  wire logic        clr_i,       // Write-ones-to-clear strobe
   input  wire logic [31:0] wdata_i,     // Write data
   input  wire logic [31:0] bmask_i,     // Byte-lane mask
   output logic      [31:0] power_o      // Register contents
);

   rps_pkg::rps_cell_s q;
   rps_pkg::rps_cell_s d;
   logic [31:0]        m;

   // Only on- and keep-bits move; reserved bits hold their reset pattern
   assign m = wdata_i & bmask_i & `RPS_WMASK;

   // Next value: zero bits in set or clear data leave the register alone
   always_comb begin
      d = q;
      if (wr_i) begin
         d.power = (q.power & ~(bmask_i & `RPS_WMASK)) | m;
      end else if (set_i) begin
         d.power = q.power | m;  // see RQ4 see RQ6 see RQ10
      end else if (clr_i) begin
         d.power = q.power & ~m;  // see RQ5 see RQ7 see RQ10
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q.power <= `RPS_POWER_RESET;  // see RQ8
      end else begin
         q <= d;
      end
   end

   assign power_o = q.power;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_set_turns_on: assert property ( // see RQ4
      set_i |=> ((power_o & $past(m)) == $past(m)))
      else $error("set write did not raise the selected bits");

   chk_clr_turns_off: assert property ( // see RQ5
      clr_i |=> ((power_o & $past(m)) == 32'h00000000))
      else $error("clear write did not drop the selected bits");

   chk_zero_bits_hold: assert property ( // see RQ10
      (set_i || clr_i) && !wr_i |=> ((power_o & ~$past(m)) == ($past(power_o) & ~$past(m))))
      else $error("zero bits of set or clear data changed the register");

   chk_reserved_fixed: assert property ( // see RQ8
      (power_o & ~`RPS_WMASK) == (`RPS_POWER_RESET & ~`RPS_WMASK))
      else $error("reserved bits left their reset pattern");

endmodule

/* design/rps_ram_power.sv */
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "rps_regs.svh"

// Notes on behaviour
// RQ1 - Set register of block n decoded at byte 0x904 plus n times 0x10.
// RQ2 - Clear register of block n decoded at byte 0x908 plus n times 0x10.
// RQ3 - Reading set or clear register returns that block's combined power state.
// RQ4 - Writing one to a set on-bit switches the section on in on mode.
// RQ5 - Writing one to a clear on-bit switches the section off in on mode.
// RQ6 - Writing one to a set keep-bit enables retention while section is off.
// RQ7 - Writing one to a clear keep-bit disables retention while section is off.
// RQ8 - Power state at 0x900 plus n times 0x10, reset 0x0000FFFF, only if present.
// RQ9 - A section that is on always retains; off mode forces every section off.
// RQ10 - Zero bits written to set or clear leave the power state unchanged.
module rps_ram_power (
   input  wire logic        core_clk_i,          // System clock, 50 MHz
   input  wire logic        arst_n_i,            // Async reset, active low
   input  wire logic [11:0] avs_address_i,       // Byte address
   input  wire logic        avs_read_i,          // Read request
   input  wire logic        avs_write_i,         // Write request
   input  wire logic [31:0] avs_writedata_i,     // Write data
   input  wire logic [3:0]  avs_byteenable_i,    // Byte enables
   output logic      [31:0] avs_readdata_o,      // Read data, registered
   output logic             avs_waitrequest_o,   // Stall, combinational
   input  wire logic        sys_off_i,           // System off mode, same clock domain
   output logic      [15:0] sec_on_o,            // Section powered, 2n+i
   output logic      [15:0] sec_keep_o           // Section retains contents, 2n+i
);

   localparam int NB = `RPS_NUM_BLOCKS;
   localparam int NS = `RPS_NUM_SECT;
   localparam logic [NB-1:0] PRESENT_MAP = `RPS_PRESENT;  // Blocks whose slave exists

   rps_pkg::rps_main_s q;
   rps_pkg::rps_main_s d;

   rps_pkg::rps_acc_e  acc;
   logic [2:0]         blk;
   logic               present;
   logic [31:0]        rd_val;
   logic [31:0]        bmask;
   logic               wr_go;
   logic [31:0]        power_w [NB];
   logic [NB-1:0]      pw_wr;
   logic [NB-1:0]      set_wr;
   logic [NB-1:0]      clr_wr;

   // Address decode; word bits only, the low two address bits are ignored
   always_comb begin
      acc = rps_pkg::RPS_ACC_NONE;
      blk = 3'h0;
      for (int n = 0; n < NB; n++) begin
         if (avs_address_i[11:2] == 10'((`RPS_POWER_OFS + n * `RPS_STRIDE) >> 2)) begin
            acc = rps_pkg::RPS_ACC_POWER;  // see RQ8
            blk = 3'(n);
         end
         if (avs_address_i[11:2] == 10'((`RPS_SET_OFS + n * `RPS_STRIDE) >> 2)) begin
            acc = rps_pkg::RPS_ACC_SET;  // see RQ1
            blk = 3'(n);
         end
         if (avs_address_i[11:2] == 10'((`RPS_CLR_OFS + n * `RPS_STRIDE) >> 2)) begin
            acc = rps_pkg::RPS_ACC_CLR;  // see RQ2
            blk = 3'(n);
         end
      end
   end

   // Absent blocks answer like unmapped space
   assign present = (acc != rps_pkg::RPS_ACC_NONE) && PRESENT_MAP[blk];  // see RQ8

   // All three registers of a block read the same stored word
   assign rd_val = present ? power_w[blk] : 32'h00000000;  // see RQ3

   // Byte-lane mask from the enables
   assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // A write lands only at the edge where waitrequest is seen low
   assign wr_go = (q.st == rps_pkg::RPS_BUS_ACK) && avs_write_i && present;

   // Per-block strobes and registers
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : gen_blk
         assign pw_wr[g]  = wr_go && (blk == 3'(g)) && (acc == rps_pkg::RPS_ACC_POWER);
         assign set_wr[g] = wr_go && (blk == 3'(g)) && (acc == rps_pkg::RPS_ACC_SET);   // see RQ1
         assign clr_wr[g] = wr_go && (blk == 3'(g)) && (acc == rps_pkg::RPS_ACC_CLR);   // see RQ2

         rps_power_cell u_cell (
            .core_clk_i (core_clk_i),
            .arst_n_i   (arst_n_i),
            .wr_i       (pw_wr[g]),
            .set_i      (set_wr[g]),
            .clr_i      (clr_wr[g]),
            .wdata_i    (avs_writedata_i),
            .bmask_i    (bmask),
            .power_o    (power_w[g])
         );
      end
   endgenerate

   // Bus state, read data capture and section outputs
   always_comb begin
      d = q;
      case (q.st)
         rps_pkg::RPS_BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               d.st    = rps_pkg::RPS_BUS_ACK;
               d.rdata = avs_read_i ? rd_val : 32'h00000000;  // see RQ3
            end
         end
         rps_pkg::RPS_BUS_ACK: begin
            d.st = rps_pkg::RPS_BUS_IDLE;
         end
         default: begin
            d.st = rps_pkg::RPS_BUS_IDLE;
         end
      endcase
      // Off mode overrides the on-bits; an on section always retains
      for (int n = 0; n < NB; n++) begin
         for (int i = 0; i < NS; i++) begin
            d.on[NS*n+i]   = power_w[n][`RPS_ON_LSB+i] && !sys_off_i;  // see RQ4 see RQ5 see RQ9
            d.keep[NS*n+i] = d.on[NS*n+i] || power_w[n][`RPS_KEEP_LSB+i];  // see RQ6 see RQ7
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q.st    <= rps_pkg::RPS_BUS_IDLE;
         q.rdata <= 32'h00000000;
         q.on    <= 16'h0000;
         q.keep  <= 16'h0000;
      end else begin
         q <= d;
      end
   end

   // One wait state: a request is held one cycle, then answered
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (q.st != rps_pkg::RPS_BUS_ACK);
   assign avs_readdata_o    = q.rdata;
   assign sec_on_o          = q.on;
   assign sec_keep_o        = q.keep;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   // Request sequences used by the one-wait check below
   sequence s_req_held;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   sequence s_answer;
      (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   endsequence

   chk_bus_one_wait: assert property (
      s_req_held |=> s_answer)
      else $error("request not answered after one wait state");

   chk_off_forces: assert property ( // see RQ9
      sys_off_i |=> (sec_on_o == 16'h0000))
      else $error("section stayed on in off mode");

   chk_on_retains: assert property ( // see RQ9
      ((sec_on_o & ~sec_keep_o) == 16'h0000))
      else $error("section on without retention");

   // Unmapped and absent addresses are answered like any other, with zero data
   chk_refused_zero: assert property ( // see RQ8
      avs_read_i && !avs_waitrequest_o && !present |-> (avs_readdata_o == 32'h00000000))
      else $error("unmapped read returned nonzero data");

   // Direct reads of the power state word return the stored value
   chk_power_read: assert property ( // see RQ8
      avs_read_i && !avs_waitrequest_o && present && (acc == rps_pkg::RPS_ACC_POWER)
      |-> (avs_readdata_o == power_w[blk]))
      else $error("power state read differs from stored word");

   // Read data stands between accesses, so a late sampler still sees the last answer
   chk_rdata_stands: assert property (
      !avs_read_i && !avs_write_i |=> $stable(avs_readdata_o))
      else $error("read data moved with no request");

   // A fresh request always sees one wait state first
   chk_wait_first: assert property (
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("new request answered without a wait state");

   // After an answer the slave is idle again, so a held request would wait once more
   chk_answer_once: assert property (
      (avs_read_i || avs_write_i) && !avs_waitrequest_o
      |=> (avs_waitrequest_o || !(avs_read_i || avs_write_i)))
      else $error("second answer without a new wait state");

   generate
      for (g = 0; g < NB; g++) begin : gen_chk
         localparam logic [11:0] SET_A = 12'(`RPS_SET_OFS + g * `RPS_STRIDE);
         localparam logic [11:0] CLR_A = 12'(`RPS_CLR_OFS + g * `RPS_STRIDE);

         sequence s_keep_set;
            set_wr[g] && avs_writedata_i[`RPS_KEEP_LSB] && avs_byteenable_i[2];
         endsequence

         sequence s_keep_clr;
            clr_wr[g] && avs_writedata_i[`RPS_KEEP_LSB] && avs_byteenable_i[2];
         endsequence

         sequence s_on_set;
            set_wr[g] && avs_writedata_i[`RPS_ON_LSB] && avs_byteenable_i[0];
         endsequence

         chk_set_decode: assert property ( // see RQ1
            (avs_write_i && !avs_waitrequest_o && avs_address_i[11:2] == SET_A[11:2])
            |-> set_wr[g])
            else $error("set register write missed its block");

         chk_clr_decode: assert property ( // see RQ2
            (avs_write_i && !avs_waitrequest_o && avs_address_i[11:2] == CLR_A[11:2])
            |-> clr_wr[g])
            else $error("clear register write missed its block");

         chk_read_mirror: assert property ( // see RQ3
            (avs_read_i && !avs_waitrequest_o &&
             (avs_address_i[11:2] == SET_A[11:2] || avs_address_i[11:2] == CLR_A[11:2]))
            |-> (avs_readdata_o == power_w[g]))
            else $error("set or clear read differs from power state");

         chk_on_output: assert property ( // see RQ4
            s_on_set ##1 !sys_off_i |=> sec_on_o[NS*g])
            else $error("section not on after set write");

         chk_keep_set: assert property ( // see RQ6
            s_keep_set |-> ##2 sec_keep_o[NS*g])
            else $error("retention not enabled after set write");

         chk_keep_clr: assert property ( // see RQ7
            s_keep_clr ##1 (!power_w[g][`RPS_ON_LSB] || sys_off_i) |=> !sec_keep_o[NS*g])
            else $error("retention still enabled after clear write");
      end
   endgenerate

   // Per-section checks; the block-level ones above only watch section 0
   generate
      for (g = 0; g < NB * NS; g++) begin : gen_sec
         // Block, section and the two bit positions that this output follows
         localparam int BN   = g / NS;
         localparam int SI   = g % NS;
         localparam int ON_B = `RPS_ON_LSB + SI;
         localparam int KP_B = `RPS_KEEP_LSB + SI;

         // Set and clear strobes for this section's bits; a bit's lane is its index over 8
         sequence s_sec_on_set;
            set_wr[BN] && avs_writedata_i[ON_B] && avs_byteenable_i[ON_B / 8];
         endsequence

         sequence s_sec_on_clr;
            clr_wr[BN] && avs_writedata_i[ON_B] && avs_byteenable_i[ON_B / 8];
         endsequence

         sequence s_sec_keep_set;
            set_wr[BN] && avs_writedata_i[KP_B] && avs_byteenable_i[KP_B / 8];
         endsequence

         sequence s_sec_keep_clr;
            clr_wr[BN] && avs_writedata_i[KP_B] && avs_byteenable_i[KP_B / 8];
         endsequence

         // A set or clear word with zeros here must leave both bits alone
         sequence s_sec_zero_hit;
            (set_wr[BN] || clr_wr[BN]) &&
            !avs_writedata_i[ON_B] && !avs_writedata_i[KP_B];
         endsequence

         // Output checks count from the edge where the write lands
         chk_sec_set_on: assert property ( // see RQ4
            s_sec_on_set ##1 !sys_off_i |=> sec_on_o[g])
            else $error("section not powered after set write");

         chk_sec_clr_off: assert property ( // see RQ5
            s_sec_on_clr |-> ##2 !sec_on_o[g])
            else $error("section still powered after clear write");

         chk_sec_keep_on: assert property ( // see RQ6
            s_sec_keep_set |-> ##2 sec_keep_o[g])
            else $error("section retention not enabled after set write");

         chk_sec_keep_off: assert property ( // see RQ7
            s_sec_keep_clr ##1 (!power_w[BN][ON_B] || sys_off_i) |=> !sec_keep_o[g])
            else $error("section retention still enabled after clear write");

         chk_sec_zero_hold: assert property ( // see RQ10
            s_sec_zero_hit |=> ($stable(power_w[BN][ON_B]) && $stable(power_w[BN][KP_B])))
            else $error("zero bit of set or clear word changed the section");

         chk_sec_keep_stay: assert property ( // see RQ6
            power_w[BN][KP_B] |=> sec_keep_o[g])
            else $error("stored keep bit did not hold retention");

         chk_sec_on_needs: assert property ( // see RQ4
            !power_w[BN][ON_B] |=> !sec_on_o[g])
            else $error("section powered without its on bit");
      end
   endgenerate

endmodule

/* test/rps_ram_power_tb.sv */
`timescale 1ns/100ps
`include "rps_regs.svh"

// Self-checking bench for the memory section power register bank
module rps_ram_power_tb;
   logic        core_clk;        // System clock
   logic        arst_n;          // Reset, active low
   logic [11:0] avs_address;     // Bus address
   logic        avs_read;        // Read request
   logic        avs_write;       // Write request
   logic [31:0] avs_writedata;   // Write data
   logic [3:0]  avs_byteenable;  // Byte enables
   logic [31:0] avs_readdata;    // Read data
   logic        avs_waitrequest; // Stall
   logic        sys_off;         // System off mode
   logic [15:0] sec_on;          // Sections powered
   logic [15:0] sec_keep;        // Sections retaining
   logic [31:0] pw [8];          // Expected power registers
   int          err_count;
   int          comparisons;

   rps_ram_power rps_ram_power_inst (
      .core_clk_i        (core_clk),
      .arst_n_i          (arst_n),
      .avs_address_i     (avs_address),
      .avs_read_i        (avs_read),
      .avs_write_i       (avs_write),
      .avs_writedata_i   (avs_writedata),
      .avs_byteenable_i  (avs_byteenable),
      .avs_readdata_o    (avs_readdata),
      .avs_waitrequest_o (avs_waitrequest),
      .sys_off_i         (sys_off),
      .sec_on_o          (sec_on),
      .sec_keep_o        (sec_keep)
   );

   // 50 MHz clock
   always #10 core_clk = ~core_clk;

   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // One bus access; the request stands until the edge where waitrequest is seen low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
      bit done;
      done = 1'b0;
      rd = 32'h0000_0000;
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      // No cycle count is assumed; only the watchdog ends a wait
      while (!done) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) begin
            rd = avs_readdata;
            done = 1'b1;
         end
      end
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Write one register of block n and update the expected image
   task automatic wreg(input int n, input logic [11:0] ofs, input logic [31:0] d,
                       input logic [3:0] be);
      logic [31:0] m;
      logic [31:0] rd;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & `RPS_WMASK;
      bus(1'b1, 12'(ofs + n * `RPS_STRIDE), d, be, rd);
      if (ofs == `RPS_SET_OFS) pw[n] = pw[n] | (d & m);
      else if (ofs == `RPS_CLR_OFS) pw[n] = pw[n] & ~(d & m);
      else pw[n] = (pw[n] & ~m) | (d & m);
   endtask

   task automatic rchk(input int n, input logic [11:0] ofs);
      logic [31:0] rd;
      bus(1'b0, 12'(ofs + n * `RPS_STRIDE), 32'h0000_0000, 4'hF, rd);
      cmp(pw[n], rd);
   endtask

   // Outputs settle two cycles after a write; three are allowed here
   task automatic ochk();
      logic [15:0] on;
      logic [15:0] kp;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      for (int b = 0; b < 16; b++) begin
         on[b] = pw[b / 2][b % 2] & !sys_off;
         kp[b] = on[b] | pw[b / 2][16 + b % 2];
      end
      cmp({16'h0000, on}, {16'h0000, sec_on});
      cmp({16'h0000, kp}, {16'h0000, sec_keep});
   endtask

   task automatic t_reset_map();
      ochk();
      for (int n = 0; n < 8; n++) begin
         rchk(n, `RPS_POWER_OFS);
         rchk(n, `RPS_SET_OFS);
         rchk(n, `RPS_CLR_OFS);
      end
   endtask

   // Clear, ignored zero and masked writes, then restore retention per block
   task automatic t_set_clear();
      for (int n = 0; n < 8; n++) begin
         wreg(n, `RPS_CLR_OFS, (n % 2) ? 32'h0003_0002 : 32'h0003_0001, 4'hF);
         ochk();
         wreg(n, `RPS_SET_OFS, 32'h0000_0000, 4'hF);
         wreg(n, `RPS_SET_OFS, 32'h0001_0000, 4'hB);
         rchk(n, `RPS_CLR_OFS);
         wreg(n, `RPS_SET_OFS, (n % 2) ? 32'h0002_0000 : 32'h0001_0000, 4'hF);
         ochk();
         rchk(n, `RPS_POWER_OFS);
      end
   endtask

   task automatic t_off_mode();
      @(posedge core_clk);
      sys_off <= 1'b1;
      ochk();
      wreg(3, `RPS_SET_OFS, 32'h0000_0003, 4'hF);
      ochk();
      rchk(3, `RPS_SET_OFS);
      @(posedge core_clk);
      sys_off <= 1'b0;
      ochk();
      wreg(6, `RPS_POWER_OFS, 32'hFFFF_FFFF, 4'hF);
      rchk(6, `RPS_POWER_OFS);
   endtask

   task automatic t_unmapped();
      logic [31:0] rd;
      bus(1'b0, 12'h90C, 32'h0000_0000, 4'hF, rd);
      cmp(32'h0000_0000, rd);
      bus(1'b1, 12'h90C, 32'hFFFF_FFFF, 4'hF, rd);
      bus(1'b1, 12'h988, 32'hFFFF_FFFF, 4'hF, rd);
      for (int n = 0; n < 8; n++) begin
         rchk(n, `RPS_POWER_OFS);
      end
      ochk();
   endtask

   // Main sequence
   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      sys_off = 1'b0;
      err_count = 0;
      comparisons = 0;
      for (int n = 0; n < 8; n++) pw[n] = `RPS_POWER_RESET;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset_map();
      t_set_clear();
      t_off_mode();
      t_unmapped();
      wrap_up();
   end

   // Watchdog: the whole run needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      wrap_up();
   end
endmodule
